/* File: bench/spa_link_sva.sv */
// Purpose: Wire-level checks on the SPI link between host and device.
// Assumes: Host half period of 13 pclk cycles; attention pin setting fixed.
// Notes: Sees only the interface signals; host reset disables all checks.
`timescale 1ns/1ps
`default_nettype none
module spa_link_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic sclk, // Serial clock
  input wire logic sel_n, // Select, active low
  input wire logic mosi, // Host data
  input wire logic miso, // Device data
  input wire logic miso_oe, // Device drives miso
  input wire logic alert_oe // Device drives attention
);
  logic [4:0] hold_cnt;
  logic [2:0] rise_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since sclk last moved; saturates so idle time never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 5'h1F;
    end else if ($changed(sclk)) begin
      hold_cnt <= 5'h00;
    end else if (hold_cnt != 5'h1F) begin
      hold_cnt <= hold_cnt + 5'h01;
    end
  end
  // Rising edges within one select period, modulo a byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt <= 3'h0;
    end else if (sel_n) begin
      rise_cnt <= 3'h0;
    end else if ($rose(sclk)) begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end
  a_sclk_idle_low: assert property (sel_n |-> !sclk)
    else $error("sclk high while deselected");
  a_half_period: assert property ($changed(sclk) |-> hold_cnt >= 5'h0C)
    else $error("sclk half period too short");
  a_sel_lead: assert property ($rose(sclk) |-> !sel_n && !$past(sel_n, 4))
    else $error("sclk rose too soon after select");
  a_mosi_steady: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_steady: assert property (sclk && $past(sclk) && miso_oe |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_miso_release: assert property (sel_n [*5] |-> !miso_oe)
    else $error("miso driven while deselected");
  a_byte_whole: assert property ($rose(sel_n) |-> rise_cnt == 3'h0)
    else $error("select ended inside a byte");
  a_alert_driven: assert property (!$fell(alert_oe))
    else $error("attention line released");
endmodule : spa_link_sva
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Host and device ends joined over the link, driven through APB.
// Assumes: Zero-wait host APB; one outbound holding byte in the device.
// Notes: Separate device reset lets the host hold the strap line low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, dev_rstn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic keep;
  logic [7:0] tx_data, rx_data;
  logic tx_valid, tx_ready, rx_valid, rx_in_frame;
  logic [2:0] slave_out_pin_function, master_out_pin_function, select_pin_function;
  logic [2:0] clock_pin_function, alert_pin_function;
  logic spi_off_by_default, pullup_control_setting, pullup_enable, spi_in_use, strap_forced;
  logic [1:0] framing_mode_setting, framing_mode_in_effect;
  logic [7:0] rxq[$];
  logic frq[$];
  logic [7:0] fb [6] = '{8'h11, 8'h7E, 8'h00, 8'h01, 8'h55, 8'hAA};
  logic [7:0] exp_rx [9] = '{8'h3C, 8'hC3, 8'h11, 8'h7E, 8'h00, 8'h01, 8'h55, 8'hAA, 8'h42};
  int failures, n_checks;
  spa_link_if spa_link_if_i ();
  spa_device spa_device_i (.pclk(pclk), .presetn(dev_rstn), .link(spa_link_if_i),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_in_frame(rx_in_frame),
    .slave_out_pin_function(slave_out_pin_function),
    .master_out_pin_function(master_out_pin_function),
    .select_pin_function(select_pin_function), .clock_pin_function(clock_pin_function),
    .alert_pin_function(alert_pin_function), .spi_off_by_default(spi_off_by_default),
    .framing_mode_setting(framing_mode_setting),
    .pullup_control_setting(pullup_control_setting),
    .framing_mode_in_effect(framing_mode_in_effect), .pullup_enable(pullup_enable),
    .spi_in_use(spi_in_use), .strap_forced(strap_forced));
  spa_host spa_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(spa_link_if_i));
  spa_link_sva spa_link_sva_i (.pclk(pclk), .presetn(presetn), .sclk(spa_link_if_i.sclk),
    .sel_n(spa_link_if_i.sel_n), .mosi(spa_link_if_i.mosi), .miso(spa_link_if_i.miso),
    .miso_oe(spa_link_if_i.miso_oe), .alert_oe(spa_link_if_i.alert_oe));
  // Free-running system clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Capture every byte the device completes
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      frq.push_back(rx_in_frame);
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One APB transfer; pready is looked at between edges to avoid races
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Start one byte, see a second start refused, poll busy, return the reply
  task automatic xfer(input logic [7:0] b, output logic [31:0] r);
    logic [31:0] s;
    logic er;
    int n;
    n = 0;
    apb(1'b1, spa_pkg::REG_CTRL, {22'h0, keep, 1'b1, b}, s, er);
    apb(1'b1, spa_pkg::REG_CTRL, {22'h0, keep, 1'b1, b}, s, er);
    chk("busy_start_err", 32'h1, {31'h0, er});
    s = 32'h1;
    while (s[spa_pkg::ST_BUSY] !== 1'b0 && n < 300) begin
      apb(1'b0, spa_pkg::REG_STATUS, 32'h0, s, er);
      n++;
    end
    chk("busy_done", 32'h0, {31'h0, s[spa_pkg::ST_BUSY]});
    st = s;
    apb(1'b0, spa_pkg::REG_RXDATA, 32'h0, r, er);
  endtask : xfer
  // Offer one outbound byte to the device; tx_ready only moves on rising edges
  task automatic dev_send(input logic [7:0] b);
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_data <= b;
    @(negedge pclk);
    while (tx_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    tx_valid <= 1'b0;
  endtask : dev_send
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog well beyond the roughly 2200 cycles the sequence needs
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    finish_test();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    dev_rstn = 1'b0;
    {psel, penable, pwrite, tx_valid, keep} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_data = 8'h00;
    {slave_out_pin_function, master_out_pin_function} = {3'h1, 3'h1};
    {select_pin_function, alert_pin_function} = {3'h1, 3'h1};
    clock_pin_function = 3'h0;
    spi_off_by_default = 1'b0;
    framing_mode_setting = 2'h2;
    pullup_control_setting = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    dev_rstn <= 1'b1;
    @(negedge pclk);
    chk("pullup_enable", 32'h1, pullup_enable);
    chk("tx_ready", 32'h1, tx_ready);
    chk("alert_line", 32'h1, spa_link_if_i.alert_line);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    xfer(8'h99, q);
    chk("disabled_miso", 32'hFF, q);
    chk("spi_in_use", 32'h0, spi_in_use);
    clock_pin_function <= 3'h1;
    dev_send(8'hA5);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("alert_queued", 32'h0, spa_link_if_i.alert_line);
    fork
      dev_send(8'h5A);
    join_none
    xfer(8'h3C, q);
    chk("host_rx0", 32'hA5, q);
    chk("status_alert", 32'h6, st);
    chk("spi_in_use", 32'h1, spi_in_use);
    chk("framing_mode", 32'h1, framing_mode_in_effect);
    chk("alert_second", 32'h0, spa_link_if_i.alert_line);
    xfer(8'hC3, q);
    chk("host_rx1", 32'h5A, q);
    chk("status_drained", 32'h4, st);
    repeat (6) @(posedge pclk);
    chk("alert_drained", 32'h1, spa_link_if_i.alert_line);
    chk("miso_released", 32'h1, spa_link_if_i.miso_line);
    // Select held low across the first five bytes, released after the last
    foreach (fb[i]) begin
      keep = (i < 5);
      xfer(fb[i], q);
      chk("host_filler", 32'h0, q);
    end
    pullup_control_setting <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pullup_off", 32'h0, pullup_enable);
    clock_pin_function <= 3'h0;
    repeat (3) @(posedge pclk);
    chk("spi_sticky", 32'h1, spi_in_use);
    apb(1'b1, spa_pkg::REG_CTRL, 32'h0000_0400, q, e);
    spi_off_by_default <= 1'b1;
    dev_rstn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("spi_reset", 32'h0, spi_in_use);
    dev_rstn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, spa_pkg::REG_CTRL, 32'h0, q, e);
    chk("strap_forced", 32'h1, strap_forced);
    xfer(8'h42, q);
    chk("strap_spi", 32'h1, spi_in_use);
    chk("rx_count", 32'd9, rxq.size());
    foreach (exp_rx[i]) begin
      if (i < rxq.size()) chk("dev_rx", {24'h0, exp_rx[i]}, {24'h0, rxq[i]});
    end
    if (frq.size() > 6) begin
      chk("outside_frame", 32'h0, frq[2]);
      chk("inside_frame", 32'h1, frq[6]);
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire

/* File: verilog/spa_device.sv */
// Purpose: SPI slave end of the link with attention output.
// Assumes: Link pins are asynchronous to pclk; SCLK below 5 Mb/s.
// Notes: One-byte outbound holding register; filler sent when empty.
// Function
// - Device is slave only, master clocks it
// - Shift outgoing bits, one per clock
// - External logic tristates MISO when deselected; code releases it itself through miso_oe
// - Master clocks at most 5 Mb/s
// - Communicate only while select is low
// - Master selects before driving MOSI data; host drives both in one cycle
// - Attention low once data is queued
// - Attention held until queue clocked out
// - Attention always driven when configured
// - Bytes go MSB first both ways
// - Mode 0: idle low, sample rising
// - Only unescaped API framing on SPI
// - Framing setting ignored while SPI used
// - Full duplex; bytes outside frames filler
// - Simultaneous valid traffic without byte loss
// - Pull-ups on after reset, software disables
// - Unconnected SPI pins rely on pull-ups
// - Enable port when four pins peripheral
// - Active on first select, until reset
// - DOUT held low at reset forces SPI; code forces it only when spi_off_by_default is set
`timescale 1ns/1ps
`default_nettype none
module spa_device (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  spa_link_if.device link, // SPI pins
  input wire logic [7:0] tx_data, // Outbound byte
  input wire logic tx_valid, // Outbound byte offered
  output logic tx_ready, // Holding register free
  output logic [7:0] rx_data, // Received byte
  output logic rx_valid, // Received byte strobe
  output logic rx_in_frame, // Received byte inside a frame
  input wire logic [2:0] slave_out_pin_function, // MISO pin setting
  input wire logic [2:0] master_out_pin_function, // MOSI pin setting
  input wire logic [2:0] select_pin_function, // Select pin setting
  input wire logic [2:0] clock_pin_function, // Clock pin setting
  input wire logic [2:0] alert_pin_function, // Attention pin setting
  input wire logic spi_off_by_default, // Variant without SPI pins
  input wire logic [1:0] framing_mode_setting, // Software framing mode
  input wire logic pullup_control_setting, // 1 keeps pull-ups on
  output logic [1:0] framing_mode_in_effect, // Mode the port uses
  output logic pullup_enable, // Input pull-ups on
  output logic spi_in_use, // SPI chosen over UART
  output logic strap_forced // DOUT strap forced SPI
);
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_low;
  logic go;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic pins_periph;
  logic port_enabled;
  logic [6:0] rx_shift;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] rx_byte;
  logic frame_flag;
  logic [7:0] tx_hold;
  logic tx_full;
  logic [7:0] tx_shift;
  logic shift_valid;
  logic need_load;
  logic load_now;
  logic accept;

  // Two-flop synchronisers for every pin from the master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= spa_pkg::SY_RESET;
      sync2 <= spa_pkg::SY_RESET;
    end else begin
      sync1 <= {link.dout_low_n, link.sclk, link.sel_n, link.mosi};
      sync2 <= sync1;
    end
  end

  // Edge finder runs on the synchronised clock only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    else sclk_q <= sync2[spa_pkg::SY_SCLK];
  end

  // Mode 0: rising edge samples, falling edge launches
  assign sclk_rise = sync2[spa_pkg::SY_SCLK] & ~sclk_q;
  assign sclk_fall = ~sync2[spa_pkg::SY_SCLK] & sclk_q;
  assign sel_low = ~sync2[spa_pkg::SY_SEL];

  // Strap is read a few cycles after release, once synchronisers settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      strap_forced <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == spa_pkg::STRAP_SETTLE) begin
        strap_done <= 1'b1;
        strap_forced <= spi_off_by_default & ~sync2[spa_pkg::SY_DOUT];
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // Port needs all four SPI pins set as peripheral functions unless the DOUT strap forced SPI
  assign pins_periph = (slave_out_pin_function == spa_pkg::PIN_FUNC_PERIPH)
                     && (master_out_pin_function == spa_pkg::PIN_FUNC_PERIPH)
                     && (select_pin_function == spa_pkg::PIN_FUNC_PERIPH)
                     && (clock_pin_function == spa_pkg::PIN_FUNC_PERIPH);
  assign port_enabled = strap_done & ((pins_periph & ~spi_off_by_default) | strap_forced);

  // Sticky choice: the first select wins the port until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spi_in_use <= 1'b0;
    else if (port_enabled & sel_low) spi_in_use <= 1'b1;
  end

  // Edges only count while selected; deselect freezes the receive shifter and bit count
  assign go = spi_in_use & sel_low;

  // Receive shifter, MSB arrives first
  assign byte_done = go & sclk_rise & (bit_cnt == spa_pkg::LAST_BIT);
  assign rx_byte = {rx_shift, sync2[spa_pkg::SY_MOSI]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= 7'h00;
      bit_cnt <= 3'h0;
    end else if (go & sclk_rise) begin
      rx_shift <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Every clocked byte is reported; the frame flag marks real ones
  spa_frame u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .byte_in(rx_byte),
    .byte_valid(byte_done),
    .in_frame(frame_flag)
  );

  // Received byte outputs, one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_in_frame <= 1'b0;
    end else begin
      rx_valid <= byte_done;
      if (byte_done) begin
        rx_data <= rx_byte;
        rx_in_frame <= frame_flag;
      end
    end
  end

  // Load at the fall after a byte, or refresh filler while deselected
  assign load_now = (need_load & ((go & sclk_fall) | ~sel_low))
                  | (~sel_low & ~need_load & ~shift_valid & tx_full
                     & (bit_cnt == 3'h0));
  assign accept = tx_valid & ~tx_full;
  assign tx_ready = ~tx_full;

  // Holding register; a queued byte survives any deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
    end else if (accept) begin
      tx_hold <= tx_data;
      tx_full <= 1'b1;
    end else if (load_now & tx_full) begin
      tx_full <= 1'b0;
    end
  end

  // Transmit shifter; new byte is ready before the next rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift <= spa_pkg::FILLER_BYTE;
      shift_valid <= 1'b0;
      need_load <= 1'b1;
    end else if (byte_done) begin
      need_load <= 1'b1;
      shift_valid <= 1'b0;
    end else if (load_now) begin
      tx_shift <= tx_full ? tx_hold : spa_pkg::FILLER_BYTE;
      shift_valid <= tx_full;
      need_load <= 1'b0;
    end else if (go & sclk_fall & ~need_load & (bit_cnt != 3'h0)) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // MISO released when deselected so shared buses stay clean
  assign link.miso = tx_shift[7];
  assign link.miso_oe = go;

  // Attention low while anything is held or still shifting out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link.alert_n <= 1'b1;
    else link.alert_n <= ~(tx_full | shift_valid);
  end
  assign link.alert_oe = (alert_pin_function == spa_pkg::PIN_FUNC_PERIPH);

  // SPI always uses plain API framing whatever software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) framing_mode_in_effect <= spa_pkg::FRAMING_API_PLAIN;
    else if (spi_in_use) framing_mode_in_effect <= spa_pkg::FRAMING_API_PLAIN;
    else framing_mode_in_effect <= framing_mode_setting;
  end

  // Pull-ups start on; idle pins then cannot upset the UART
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pullup_enable <= 1'b1;
    else pullup_enable <= pullup_control_setting;
  end
endmodule : spa_device
`default_nettype wire

/* File: verilog/spa_frame.sv */
// Purpose: Tracks API frame boundaries in a byte stream.
// Assumes: Unescaped framing: delimiter, two length bytes, body, checksum.
// Notes: Output flags whether the offered byte belongs to a frame.
`timescale 1ns/1ps
`default_nettype none
module spa_frame (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] byte_in, // Byte just completed
  input wire logic byte_valid, // Byte strobe
  output logic in_frame // Offered byte lies inside a frame
);
  typedef enum logic [1:0] {F_HUNT, F_LEN_HI, F_LEN_LO, F_BODY} spa_fstate_e;
  spa_fstate_e state;
  logic [7:0] len_hi;
  logic [15:0] remain;

  // Bytes outside frames are filler
  assign in_frame = (state != F_HUNT) || (byte_in == spa_pkg::FRAME_DELIM);

  // No escape handling: the delimiter value is literal inside frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= F_HUNT;
      len_hi <= 8'h00;
      remain <= 16'h0000;
    end else if (byte_valid) begin
      unique case (state)
        F_HUNT: if (byte_in == spa_pkg::FRAME_DELIM) state <= F_LEN_HI;
        F_LEN_HI: begin
          len_hi <= byte_in;
          state <= F_LEN_LO;
        end
        F_LEN_LO: begin
          remain <= {len_hi, byte_in};
          state <= F_BODY;
        end
        F_BODY: begin
          if (remain == 16'h0000) state <= F_HUNT;
          else remain <= remain - 16'h0001;
        end
      endcase
    end
  end
endmodule : spa_frame
`default_nettype wire

/* File: verilog/spa_host.sv */
// Purpose: SPI master end, ordered by software over APB.
// Assumes: Zero-wait APB slave; one byte per start command.
// Notes: SCLK is divided from pclk and never exceeds 5 Mb/s.
`timescale 1ns/1ps
`default_nettype none
module spa_host (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  spa_link_if.host link // SPI pins
);
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW} spa_hstate_e;
  spa_hstate_e state;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [4:0] cnt;
  logic [2:0] bits;
  logic [7:0] tx_byte;
  logic [6:0] rx_shift;
  logic [7:0] rx_data;
  logic rx_flag;
  logic rx_frame;
  logic frame_flag;
  logic keep_sel;
  logic busy;
  logic acc;
  logic wr_ctrl;
  logic rd_rx;
  logic mapped;
  logic start;
  logic done;
  logic [7:0] rx_byte;

  // Two-flop synchronisers on MISO and attention
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {link.alert_line, link.miso_line};
      sync2 <= sync1;
    end
  end

  // APB decode; always ready, errors on holes and busy starts
  assign acc = psel & penable;
  assign mapped = (paddr == spa_pkg::REG_CTRL) || (paddr == spa_pkg::REG_STATUS)
                || (paddr == spa_pkg::REG_RXDATA);
  assign busy = (state != H_IDLE);
  assign wr_ctrl = acc & pwrite & (paddr == spa_pkg::REG_CTRL);
  assign start = wr_ctrl & pwdata[spa_pkg::CTRL_START] & ~busy;
  assign rd_rx = acc & ~pwrite & (paddr == spa_pkg::REG_RXDATA);
  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | (wr_ctrl & pwdata[spa_pkg::CTRL_START] & busy));

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= spa_pkg::RD_ZERO;
    else if (psel & ~penable & ~pwrite) begin
      if (paddr == spa_pkg::REG_STATUS)
        prdata <= {28'h0000000, rx_frame, rx_flag, ~sync2[1], busy};
      else if (paddr == spa_pkg::REG_RXDATA) prdata <= {24'h000000, rx_data};
      else prdata <= spa_pkg::RD_ZERO;
    end
  end

  // Strap line for forcing SPI during the device's reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link.dout_low_n <= 1'b1;
    else if (wr_ctrl) link.dout_low_n <= ~pwdata[spa_pkg::CTRL_DOUT_LOW];
  end

  // Sequencer: select and MSB on MOSI driven in the same cycle, clock idles low
  assign rx_byte = {rx_shift, sync2[0]};
  // Byte ends at the eighth rise, while the last bit is still being sampled
  assign done = (state == H_LOW) && (cnt == 5'h00) && (bits == spa_pkg::LAST_BIT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= H_IDLE;
      link.sclk <= 1'b0;
      link.sel_n <= 1'b1;
      link.mosi <= 1'b0;
      cnt <= 5'h00;
      bits <= 3'h0;
      tx_byte <= 8'h00;
      rx_shift <= 7'h00;
      keep_sel <= 1'b0;
    end else begin
      if (cnt != 5'h00) cnt <= cnt - 5'h01;
      unique case (state)
        H_IDLE: if (start) begin
          tx_byte <= pwdata[7:0];
          keep_sel <= pwdata[spa_pkg::CTRL_KEEP_SEL];
          link.sel_n <= 1'b0;
          link.mosi <= pwdata[7];
          bits <= 3'h0;
          cnt <= spa_pkg::SCLK_HALF_RELOAD;
          state <= H_LEAD;
        end
        H_LEAD, H_LOW: if (cnt == 5'h00) begin
          link.sclk <= 1'b1;
          rx_shift <= rx_byte[6:0];
          cnt <= spa_pkg::SCLK_HALF_RELOAD;
          state <= H_HIGH;
        end
        H_HIGH: if (cnt == 5'h00) begin
          link.sclk <= 1'b0;
          cnt <= spa_pkg::SCLK_HALF_RELOAD;
          if (bits == spa_pkg::LAST_BIT) begin
            link.sel_n <= ~keep_sel;
            state <= H_IDLE;
          end else begin
            link.mosi <= tx_byte[3'h6 - bits];
            bits <= bits + 3'h1;
            state <= H_LOW;
          end
        end
      endcase
    end
  end

  // Received byte tagged by the frame tracker
  spa_frame u_frame (
    .pclk(pclk),
    .presetn(presetn),
    .byte_in(rx_byte),
    .byte_valid(done),
    .in_frame(frame_flag)
  );

  // Sticky receive flag; a new byte beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 8'h00;
      rx_flag <= 1'b0;
      rx_frame <= 1'b0;
    end else if (done) begin
      rx_data <= rx_byte;
      rx_flag <= 1'b1;
      rx_frame <= frame_flag;
    end else if (rd_rx) begin
      rx_flag <= 1'b0;
    end
  end
endmodule : spa_host
`default_nettype wire

/* File: verilog/spa_link_if.sv */
// Purpose: Four-wire SPI link plus attention and DOUT strap line.
// Assumes: Undriven lines read as pulled high.
// Notes: Wire levels are resolved here from the output enables.
`timescale 1ns/1ps
`default_nettype none
interface spa_link_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic alert_n;
  logic alert_oe;
  logic dout_low_n;
  logic miso_line;
  logic alert_line;
  // Pull-ups hold released lines high
  assign miso_line = miso_oe ? miso : 1'b1;
  assign alert_line = alert_oe ? alert_n : 1'b1;
  modport device (
    input sclk, sel_n, mosi, dout_low_n,
    output miso, miso_oe, alert_n, alert_oe
  );
  modport host (
    output sclk, sel_n, mosi, dout_low_n,
    input miso_line, alert_line
  );
endinterface : spa_link_if
`default_nettype wire

/* File: verilog/spa_pkg.sv */
// Purpose: Shared constants for the SPI slave port with attention.
// Assumes: pclk at 125 MHz on both ends.
// Notes: Host register map is a small APB block of word registers.
package spa_pkg;
  // Clock and link timing
  localparam int PCLK_NS = 8;
  localparam int SCLK_MIN_PERIOD_NS = 200; // 5 Mb/s ceiling
  localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + PCLK_NS - 1) / PCLK_NS;
  localparam logic [4:0] SCLK_HALF_RELOAD = 5'(SCLK_HALF_CYC - 1);
  // Synchroniser bit positions and reset levels
  localparam int SY_MOSI = 0;
  localparam int SY_SEL = 1;
  localparam int SY_SCLK = 2;
  localparam int SY_DOUT = 3;
  localparam logic [3:0] SY_RESET = 4'hA; // dout high, sclk low, sel high
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Pin function and framing codes
  localparam logic [2:0] PIN_FUNC_PERIPH = 3'h1;
  localparam logic [1:0] FRAMING_API_PLAIN = 2'h1;
  localparam logic [7:0] FRAME_DELIM = 8'h7E;
  localparam logic [7:0] FILLER_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Host APB register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RXDATA = 12'h008;
  localparam int CTRL_START = 8;
  localparam int CTRL_KEEP_SEL = 9;
  localparam int CTRL_DOUT_LOW = 10;
  localparam int ST_BUSY = 0;
  localparam int ST_ALERT = 1;
  localparam int ST_RXV = 2;
  localparam int ST_INFRAME = 3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : spa_pkg
